// ### rtc_supmon_map.svh
// Register indices, field positions, reset values and timing counts of the supply and oscillator monitor.
`ifndef RTC_SUPMON_MAP_SVH
`define RTC_SUPMON_MAP_SVH

// Register indices; the byte address is four times the index.
`define REG_SECONDS_IDX 8'h01
`define REG_WDOG_IDX 8'h09
`define REG_FLAGS_IDX 8'h0f
`define REG_CFG_IDX 8'h14
`define REG_IRQ_STAT_IDX 8'h15
`define REG_IRQ_MASK_IDX 8'h16

// Field positions.
`define SEC_STOP_BIT 7
`define WDOG_OSC_FAIL_IRQ_ENABLE_BIT 7
`define FLAG_WDOG_BIT 7
`define FLAG_ALARM_BIT 6
`define FLAG_BATLOW_BIT 4
`define FLAG_OSCFAIL_BIT 2
`define CFG_THS_BIT 0
`define CFG_PWRUP_LOAD_BIT 1
`define IRQ_OSC_BIT 0
`define IRQ_BAT_BIT 1
`define IRQ_DESEL_BIT 2

// Reset values.
`define SECONDS_RESET 8'h00
`define WDOG_RESET 8'h00
`define CFG_RESET 2'h0
`define IRQ_RESET 3'h0

// Timing.
`define CLK_HZ 100000000
`define CLK_PERIOD_NS 10
`define OSC_TAP_HZ 4096
`define OSC_MISS_PULSES 5
`define OSC_MISS_CYC (`OSC_MISS_PULSES * `CLK_HZ / `OSC_TAP_HZ)
`define BAT_SETTLE_NS 1000
`define BAT_SETTLE_CYC ((`BAT_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtc_supmon_pkg.sv
// Types shared by the supply and oscillator monitor.
package rtc_supmon_pkg;

  // Analog comparator and pin levels, synchronised as one group.
  typedef struct packed {
    logic below_262;
    logic below_288;
    logic bat_low;
    logic backup;
    logic tap;
  } pin_t;

  // One APB request as seen by the slave.
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [9:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  // Battery check sequence.
  typedef enum logic [1:0] {
    CHK_IDLE,
    CHK_SETTLE,
    CHK_SAMPLE
  } chk_state_t;

endpackage : rtc_supmon_pkg

// ### osc_fail_detect.sv
// Missing-pulse detector on the synchronised oscillator divider tap.
`timescale 1ns/100ps
module osc_fail_detect #(
  parameter int MISS_CYCLES = 122070
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Tap edge and result.
  input wire logic tap_pulse,
  output logic missing
);

  localparam int W = $clog2(MISS_CYCLES + 1);
  localparam logic [W-1:0] LIMIT = W'(MISS_CYCLES);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic missing_reg;
  logic missing_next;

  // The count saturates so that a dead oscillator keeps the result high without wrapping.
  always_comb begin
    if (tap_pulse) begin
      cnt_next = '0;
    end else if (cnt_reg == LIMIT) begin
      cnt_next = cnt_reg;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
    missing_next = (cnt_next == LIMIT);
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      missing_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      missing_reg <= missing_next;
    end
  end

  assign missing = missing_reg;

  a_tap_restarts: assert property (@(posedge clk) disable iff (!rst_n) tap_pulse |=> !missing)
    else $error("A tap edge did not restart the missing-pulse count.");

endmodule : osc_fail_detect

// ### rtc_supply_and_osc_monitor.sv
// Supply deselect, oscillator-fail and battery-low supervision with an APB register file.
`timescale 1ns/100ps

`include "rtc_supmon_map.svh"

// How it works
// - While supply is below the deselect level, bus accesses error and writes are dropped.
// - Threshold select bit picks the 2.62 V comparator at 0, 2.88 V at 1.
// - About five missing 4 kHz tap pulses set the oscillator-fail flag.
// - Oscillator-fail flag is set at first power-up and while the stop bit halts the oscillator.
// - Battery below the 2.5 V reference sets the battery-low flag when checked.
// - Battery is checked on power-up from backup and at midnight rollover on main supply.
// - The midnight check loads the battery node before comparing.
// - Power-up check is unloaded unless the variant load option is enabled.
// - Flags register holds watchdog, alarm, battery-low and oscillator-fail bits; others zero.
// - Watchdog register bit 7 is oscillator-fail interrupt enable; bits 6 to 0 watchdog fields.
// - Seconds register bit 7 stops the oscillator when set.
module rtc_supply_and_osc_monitor #(
  parameter bit HAS_THS = 1'b1,
  parameter bit PWRUP_LOAD_OPT = 1'b1,
  parameter int OSC_MISS_CYCLES = `OSC_MISS_CYC,
  parameter int SETTLE_CYCLES = `BAT_SETTLE_CYC
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Analog comparators and oscillator tap, asynchronous.
  input wire logic VCC_BELOW_262,
  input wire logic VCC_BELOW_288,
  input wire logic BAT_BELOW_REF,
  input wire logic ON_BACKUP,
  input wire logic OSC_TAP_4K,
  // Events from timekeeping logic on this clock.
  input wire logic MIDNIGHT_TICK,
  input wire logic WDOG_EXPIRED,
  input wire logic ALARM_MATCH,
  // Controls and status.
  output logic OSC_STOP,
  output logic [6:0] WDOG_CFG,
  output logic BAT_LOAD,
  output logic DESELECTED,
  output logic IRQ
);

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);

  // True when the byte address selects the given register index.
  function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
    reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : reg_hit

  rtc_supmon_pkg::apb_req_t req;
  rtc_supmon_pkg::pin_t pin_raw;
  rtc_supmon_pkg::pin_t pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg;
  rtc_supmon_pkg::pin_t pin_f_next;
  rtc_supmon_pkg::chk_state_t chk_state_reg, chk_state_next;
  logic [CW-1:0] chk_cnt_reg, chk_cnt_next;
  logic chk_loaded_reg, chk_loaded_next;
  logic bat_load_reg, bat_load_next;
  logic tap_prev_reg, backup_prev_reg;
  logic [7:0] sec_reg, sec_next;
  logic [7:0] wdog_reg, wdog_next;
  logic of_reg, of_next, bl_reg, bl_next, wdf_reg, wdf_next, af_reg, af_next;
  logic [1:0] cfg_reg, cfg_next;
  logic [2:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic err_reg, err_next;
  logic desel_reg, desel_next;
  logic setup, access, wr_ok, rd_ok, mapped;
  logic tap_pulse, osc_missing, of_set, bl_set, trig_pwrup, trig_mid;
  logic [7:0] flags_rd, rd_mux;
  logic [2:0] irq_ev;

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  assign pin_raw = '{below_262: VCC_BELOW_262, below_288: VCC_BELOW_288, bat_low: BAT_BELOW_REF,
                     backup: ON_BACKUP, tap: OSC_TAP_4K};

  // A bit of the filtered group moves only once the second and third stages agree.
  always_comb begin
    pin_f_next = rtc_supmon_pkg::pin_t'((pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                                        | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg)));
  end

  // Synchroniser stages and edge history.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
      pin_f_reg <= '0;
      tap_prev_reg <= 1'b0;
      backup_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_f_reg <= pin_f_next;
      tap_prev_reg <= pin_f_reg.tap;
      backup_prev_reg <= pin_f_reg.backup;
    end
  end

  assign tap_pulse = pin_f_reg.tap & ~tap_prev_reg;
  assign trig_pwrup = backup_prev_reg & ~pin_f_reg.backup;
  assign trig_mid = MIDNIGHT_TICK & ~pin_f_reg.backup;

  osc_fail_detect #(
    .MISS_CYCLES(OSC_MISS_CYCLES)
  ) u_osc_fail_detect (
    .clk(CLK),
    .rst_n(RST_N),
    .tap_pulse(tap_pulse),
    .missing(osc_missing)
  );

  // Battery check sequence; the settle time gives the loaded node time before sampling.
  always_comb begin
    chk_state_next = chk_state_reg;
    chk_cnt_next = chk_cnt_reg;
    chk_loaded_next = chk_loaded_reg;
    bl_set = 1'b0;
    case (chk_state_reg)
      rtc_supmon_pkg::CHK_IDLE: begin
        chk_cnt_next = '0;
        if (trig_pwrup) begin
          chk_loaded_next = cfg_reg[`CFG_PWRUP_LOAD_BIT];
          chk_state_next = cfg_reg[`CFG_PWRUP_LOAD_BIT] ? rtc_supmon_pkg::CHK_SETTLE : rtc_supmon_pkg::CHK_SAMPLE;
        end else if (trig_mid) begin
          chk_loaded_next = 1'b1;
          chk_state_next = rtc_supmon_pkg::CHK_SETTLE;
        end
      end
      rtc_supmon_pkg::CHK_SETTLE: begin
        chk_cnt_next = chk_cnt_reg + 1'b1;
        if (chk_cnt_reg == SETTLE_LAST) begin
          chk_state_next = rtc_supmon_pkg::CHK_SAMPLE;
        end
      end
      rtc_supmon_pkg::CHK_SAMPLE: begin
        bl_set = pin_f_reg.bat_low;
        chk_loaded_next = 1'b0;
        chk_state_next = rtc_supmon_pkg::CHK_IDLE;
      end
      default: begin
        chk_state_next = rtc_supmon_pkg::CHK_IDLE;
      end
    endcase
    bat_load_next = (chk_state_next == rtc_supmon_pkg::CHK_SETTLE)
                    || ((chk_state_next == rtc_supmon_pkg::CHK_SAMPLE) && chk_loaded_next);
  end

  // Battery check registers.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      chk_state_reg <= rtc_supmon_pkg::CHK_IDLE;
      chk_cnt_reg <= '0;
      chk_loaded_reg <= 1'b0;
      bat_load_reg <= 1'b0;
    end else begin
      chk_state_reg <= chk_state_next;
      chk_cnt_reg <= chk_cnt_next;
      chk_loaded_reg <= chk_loaded_next;
      bat_load_reg <= bat_load_next;
    end
  end

  // Bus phases and decode; the read data is captured in the setup cycle so it leaves a flip-flop.
  assign setup = req.sel & ~req.enable;
  assign access = req.sel & req.enable;
  assign mapped = reg_hit(req.addr, `REG_SECONDS_IDX) | reg_hit(req.addr, `REG_WDOG_IDX)
                | reg_hit(req.addr, `REG_FLAGS_IDX) | reg_hit(req.addr, `REG_CFG_IDX)
                | reg_hit(req.addr, `REG_IRQ_STAT_IDX) | reg_hit(req.addr, `REG_IRQ_MASK_IDX);
  assign wr_ok = access & req.write & ~err_reg & ~desel_reg;
  assign rd_ok = access & ~req.write & ~err_reg;

  always_comb begin
    flags_rd = 8'h00;
    flags_rd[`FLAG_WDOG_BIT] = wdf_reg;
    flags_rd[`FLAG_ALARM_BIT] = af_reg;
    flags_rd[`FLAG_BATLOW_BIT] = bl_reg;
    flags_rd[`FLAG_OSCFAIL_BIT] = of_reg;
    rd_mux = 8'h00;
    if (reg_hit(req.addr, `REG_SECONDS_IDX)) rd_mux = sec_reg;
    if (reg_hit(req.addr, `REG_WDOG_IDX)) rd_mux = wdog_reg;
    if (reg_hit(req.addr, `REG_FLAGS_IDX)) rd_mux = flags_rd;
    if (reg_hit(req.addr, `REG_CFG_IDX)) rd_mux = {6'h00, cfg_reg};
    if (reg_hit(req.addr, `REG_IRQ_STAT_IDX)) rd_mux = {5'h00, irq_stat_reg};
    if (reg_hit(req.addr, `REG_IRQ_MASK_IDX)) rd_mux = {5'h00, irq_mask_reg};
  end

  // Register file next values; hardware sets beat a clearing write in the same cycle.
  always_comb begin
    err_next = err_reg;
    prdata_next = prdata_reg;
    if (setup) begin
      err_next = desel_reg | ~mapped;
      prdata_next = (desel_reg | ~mapped) ? 32'h0000_0000 : {24'h00_0000, rd_mux};
    end
    sec_next = sec_reg;
    wdog_next = wdog_reg;
    cfg_next = cfg_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_ok && reg_hit(req.addr, `REG_SECONDS_IDX)) sec_next = req.wdata[7:0];
    if (wr_ok && reg_hit(req.addr, `REG_WDOG_IDX)) wdog_next = req.wdata[7:0];
    // Threshold and load options only exist on variants that have them.
    if (wr_ok && reg_hit(req.addr, `REG_CFG_IDX)) cfg_next = req.wdata[1:0] & {PWRUP_LOAD_OPT, HAS_THS};
    if (wr_ok && reg_hit(req.addr, `REG_IRQ_MASK_IDX)) irq_mask_next = req.wdata[2:0];
    of_set = osc_missing | sec_reg[`SEC_STOP_BIT];
    of_next = of_set | (of_reg & ~(wr_ok && reg_hit(req.addr, `REG_FLAGS_IDX) && !req.wdata[`FLAG_OSCFAIL_BIT]));
    bl_next = bl_set | (bl_reg & ~(wr_ok && reg_hit(req.addr, `REG_FLAGS_IDX) && !req.wdata[`FLAG_BATLOW_BIT]));
    wdf_next = WDOG_EXPIRED | (wdf_reg & ~(wr_ok && reg_hit(req.addr, `REG_FLAGS_IDX) && !req.wdata[`FLAG_WDOG_BIT]));
    af_next = ALARM_MATCH | (af_reg & ~(wr_ok && reg_hit(req.addr, `REG_FLAGS_IDX) && !req.wdata[`FLAG_ALARM_BIT]));
    desel_next = cfg_reg[`CFG_THS_BIT] ? pin_f_reg.below_288 : pin_f_reg.below_262;
    irq_ev = 3'h0;
    irq_ev[`IRQ_OSC_BIT] = of_next & ~of_reg & wdog_reg[`WDOG_OSC_FAIL_IRQ_ENABLE_BIT];
    irq_ev[`IRQ_BAT_BIT] = bl_next & ~bl_reg;
    irq_ev[`IRQ_DESEL_BIT] = desel_next & ~desel_reg;
    // A read of the status clears it, but an event in the same cycle survives.
    irq_stat_next = irq_ev | ((rd_ok && reg_hit(req.addr, `REG_IRQ_STAT_IDX)) ? 3'h0 : irq_stat_reg);
  end

  // Register file state.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      err_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      sec_reg <= `SECONDS_RESET;
      wdog_reg <= `WDOG_RESET;
      cfg_reg <= `CFG_RESET;
      irq_mask_reg <= `IRQ_RESET;
      irq_stat_reg <= `IRQ_RESET;
      of_reg <= 1'b1;
      bl_reg <= 1'b0;
      wdf_reg <= 1'b0;
      af_reg <= 1'b0;
      desel_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
      prdata_reg <= prdata_next;
      sec_reg <= sec_next;
      wdog_reg <= wdog_next;
      cfg_reg <= cfg_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      of_reg <= of_next;
      bl_reg <= bl_next;
      wdf_reg <= wdf_next;
      af_reg <= af_next;
      desel_reg <= desel_next;
    end
  end

  // Outputs.
  assign PREADY = access;
  assign PSLVERR = access & err_reg;
  assign PRDATA = prdata_reg;
  assign OSC_STOP = sec_reg[`SEC_STOP_BIT];
  assign WDOG_CFG = wdog_reg[6:0];
  assign BAT_LOAD = bat_load_reg;
  assign DESELECTED = desel_reg;
  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_desel_no_write: assert property (access && req.write && desel_reg |=> $stable(sec_reg) && $stable(wdog_reg))
    else $error("A write changed a register while deselected.");
  a_desel_error: assert property (setup && desel_reg |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("Deselected access did not answer with an error.");
  a_thresh_low: assert property (!cfg_reg[`CFG_THS_BIT] && pin_f_reg.below_262 |=> desel_reg)
    else $error("Low threshold did not deselect.");
  a_thresh_high: assert property (cfg_reg[`CFG_THS_BIT] && !pin_f_reg.below_288 |=> !desel_reg)
    else $error("High threshold deselected above its level.");
  a_osc_missing: assert property (osc_missing |=> of_reg)
    else $error("Missing tap pulses did not set the oscillator-fail flag.");
  a_stop_sets_of: assert property (OSC_STOP |=> of_reg)
    else $error("Stopped oscillator left the oscillator-fail flag clear.");
  a_bat_sample: assert property (chk_state_reg == rtc_supmon_pkg::CHK_SAMPLE && pin_f_reg.bat_low |=> bl_reg)
    else $error("Low battery sample did not set the battery-low flag.");
  a_midnight_check: assert property (trig_mid && !trig_pwrup && chk_state_reg == rtc_supmon_pkg::CHK_IDLE
                                     |=> chk_state_reg == rtc_supmon_pkg::CHK_SETTLE)
    else $error("Midnight rollover did not start a battery check.");
  a_rollover_load: assert property (chk_state_reg == rtc_supmon_pkg::CHK_SETTLE |-> BAT_LOAD)
    else $error("Battery not loaded during settle.");
  a_pwrup_unloaded: assert property (trig_pwrup && chk_state_reg == rtc_supmon_pkg::CHK_IDLE
                                     && !cfg_reg[`CFG_PWRUP_LOAD_BIT] |=> !BAT_LOAD [*2])
    else $error("Unloaded power-up check applied the load.");
  a_flags_reserved: assert property (setup && !desel_reg && reg_hit(req.addr, `REG_FLAGS_IDX)
                                     |=> PRDATA[31:8] == 24'h00_0000 && PRDATA[5] == 1'b0
                                     && PRDATA[3] == 1'b0 && PRDATA[1:0] == 2'h0)
    else $error("Reserved flags bits read nonzero.");
  a_flag_sticky: assert property (of_reg && !(wr_ok && reg_hit(req.addr, `REG_FLAGS_IDX)) |=> of_reg)
    else $error("Oscillator-fail flag cleared without a write.");

  c_loaded_check: cover property (chk_state_reg == rtc_supmon_pkg::CHK_SAMPLE && chk_loaded_reg && pin_f_reg.bat_low);
  c_deselect: cover property ($rose(desel_reg));
  c_osc_fail: cover property ($rose(osc_missing));
  c_irq: cover property ($rose(IRQ));

endmodule : rtc_supply_and_osc_monitor

// ### rtc_env_model.sv
// Model of the oscillator divider tap that feeds the monitor, with a fault input.
`timescale 1ns/100ps
module rtc_env_model #(
  parameter int HALF_CYCLES = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Oscillator control and tap.
  input wire logic osc_stop,
  input wire logic osc_fault,
  output logic tap
);
  int count;

  // The tap freezes while stopped or faulted, as a dead crystal would; a frozen level is the hazard the detector sees.
  // halted tap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= 0;
      tap <= 1'b0;
    end else if (!osc_stop && !osc_fault) begin
      count <= (count == HALF_CYCLES - 1) ? 0 : count + 1;
      if (count == HALF_CYCLES - 1) begin
        tap <= ~tap;
      end
    end
  end
endmodule : rtc_env_model

// ### rtc_supply_and_osc_monitor_tb_top.sv
// Self-checking bench for the supply and oscillator monitor.
`timescale 1ns/100ps
`include "rtc_supmon_map.svh"
module rtc_supply_and_osc_monitor_tb_top;
  localparam int SETTLE = 4;
  logic clk, rst_n, psel, penable, pwrite, b262, b288, bat_low, backup, tick, wdog, alarm, fault;
  logic pready, pslverr, osc_stop, bat_load, deselected, irq, tap, errv;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdv, seed, v, w;
  logic [6:0] wdog_cfg;
  int bad_count, n_compared, cycles, n;

  // Device under test with shortened miss and settle counts.
  rtc_supply_and_osc_monitor #(.OSC_MISS_CYCLES(200), .SETTLE_CYCLES(SETTLE)) uut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .VCC_BELOW_262(b262),
    .VCC_BELOW_288(b288), .BAT_BELOW_REF(bat_low), .ON_BACKUP(backup), .OSC_TAP_4K(tap),
    .MIDNIGHT_TICK(tick), .WDOG_EXPIRED(wdog), .ALARM_MATCH(alarm), .OSC_STOP(osc_stop),
    .WDOG_CFG(wdog_cfg), .BAT_LOAD(bat_load), .DESELECTED(deselected), .IRQ(irq));

  // Tap source follows the stop bit, so a stop really halts pulses.
  rtc_env_model env (.clk(clk), .rst_n(rst_n), .osc_stop(osc_stop), .osc_fault(fault), .tap(tap));

  // Clock of 10 ns period.
  always #5 clk = ~clk;

  // Hang guard; the tests need about 1700 cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("COUNTS compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdv, exp);
  endtask : rdchk

  task wait_cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : wait_cyc

  // Counts the cycles the battery load is applied after a check starts.
  task count_load(output int cnt);
    cnt = 0;
    repeat (30) begin
      @(posedge clk);
      if (bat_load === 1'b1) cnt++;
    end
  endtask : count_load

  // One-cycle event pulse: 0 midnight tick, 1 watchdog expiry, 2 alarm match.
  task pulse(input int which);
    if (which == 0) begin
      tick <= 1'b1;
    end else if (which == 1) begin
      wdog <= 1'b1;
    end else begin
      alarm <= 1'b1;
    end
    @(posedge clk);
    {tick, wdog, alarm} <= 3'b000;
  endtask : pulse

  // Expected flags word: watchdog, alarm, battery-low and oscillator-fail.
  function logic [31:0] flags_of(input logic wf, input logic af, input logic bl, input logic of);
    return {24'h0, wf, af, 1'b0, bl, 1'b0, of, 2'b00};
  endfunction : flags_of

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Main sequence.
  initial begin
    {clk, rst_n, psel, penable, pwrite, b262, b288, bat_low, backup, tick, wdog, alarm, fault} = '0;
    paddr = '0;
    pwdata = '0;
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    seed = 32'h52b7;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`REG_FLAGS_IDX, flags_of(0, 0, 0, 1));
    rdchk(`REG_SECONDS_IDX, 32'h0);
    rdchk(`REG_WDOG_IDX, 32'h0);
    wait_cyc(400);
    apb(1'b1, `REG_FLAGS_IDX, 32'hff);
    rdchk(`REG_FLAGS_IDX, flags_of(0, 0, 0, 1));
    apb(1'b1, `REG_FLAGS_IDX, 32'h0);
    rdchk(`REG_FLAGS_IDX, 32'h0);
    $display("TEST reset and clear done");
    for (int i = 0; i < 8; i++) begin
      v = xs() & 32'h7f;
      w = xs() & 32'hff;
      apb(1'b1, `REG_SECONDS_IDX, v);
      apb(1'b1, `REG_WDOG_IDX, w);
      wait_cyc(1);
      chk(wdog_cfg, w & 32'h7f);
      chk(osc_stop, 1'b0);
      rdchk(`REG_SECONDS_IDX, v);
      rdchk(`REG_WDOG_IDX, w);
    end
    $display("TEST random registers done");
    apb(1'b1, `REG_SECONDS_IDX, 32'h80);
    wait_cyc(1);
    chk(osc_stop, 1'b1);
    wait_cyc(10);
    rdchk(`REG_FLAGS_IDX, flags_of(0, 0, 0, 1));
    apb(1'b1, `REG_SECONDS_IDX, 32'h0);
    wait_cyc(400);
    rdchk(`REG_FLAGS_IDX, flags_of(0, 0, 0, 1));
    apb(1'b1, `REG_FLAGS_IDX, 32'h0);
    rdchk(`REG_FLAGS_IDX, 32'h0);
    fault <= 1'b1;
    wait_cyc(100);
    rdchk(`REG_FLAGS_IDX, 32'h0);
    wait_cyc(200);
    rdchk(`REG_FLAGS_IDX, flags_of(0, 0, 0, 1));
    fault <= 1'b0;
    wait_cyc(100);
    rdchk(`REG_FLAGS_IDX, flags_of(0, 0, 0, 1));
    apb(1'b1, `REG_FLAGS_IDX, 32'h0);
    $display("TEST oscillator fail done");
    apb(1'b1, `REG_IRQ_MASK_IDX, 32'h2);
    apb(1'b0, `REG_IRQ_STAT_IDX, 32'h0);
    bat_low <= 1'b1;
    wait_cyc(8);
    pulse(0);
    count_load(n);
    chk(n, SETTLE + 1);
    rdchk(`REG_FLAGS_IDX, flags_of(0, 0, 1, 0));
    chk(irq, 1'b1);
    rdchk(`REG_IRQ_STAT_IDX, 32'h2);
    wait_cyc(1);
    chk(irq, 1'b0);
    bat_low <= 1'b0;
    wait_cyc(8);
    rdchk(`REG_FLAGS_IDX, flags_of(0, 0, 1, 0));
    apb(1'b1, `REG_FLAGS_IDX, 32'h0);
    pulse(0);
    count_load(n);
    rdchk(`REG_FLAGS_IDX, 32'h0);
    // Power-up from backup, unloaded and then loaded.
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `REG_CFG_IDX, {30'h0, i[0], 1'b0});
      bat_low <= 1'b1;
      backup <= 1'b1;
      wait_cyc(10);
      backup <= 1'b0;
      count_load(n);
      chk(n, i ? SETTLE + 1 : 0);
      rdchk(`REG_FLAGS_IDX, flags_of(0, 0, 1, 0));
      apb(1'b1, `REG_FLAGS_IDX, 32'h0);
    end
    bat_low <= 1'b0;
    $display("TEST battery checks done");
    apb(1'b1, `REG_IRQ_MASK_IDX, 32'h0);
    apb(1'b0, `REG_IRQ_STAT_IDX, 32'h0);
    // Supply between the two thresholds deselects only with the higher one chosen.
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, `REG_CFG_IDX, t);
      b288 <= 1'b1;
      wait_cyc(10);
      chk(deselected, t[0]);
      apb(1'b1, `REG_SECONDS_IDX, 32'h22 + t);
      chk(errv, t[0]);
      b262 <= 1'b1;
      wait_cyc(10);
      chk(deselected, 1'b1);
      apb(1'b0, `REG_SECONDS_IDX, 32'h0);
      chk(errv, 1'b1);
      chk(rdv, 32'h0);
      {b262, b288} <= 2'b00;
      wait_cyc(10);
      rdchk(`REG_SECONDS_IDX, 32'h22);
    end
    chk(irq, 1'b0);
    rdchk(`REG_IRQ_STAT_IDX, 32'h4);
    rdchk(`REG_IRQ_STAT_IDX, 32'h0);
    $display("TEST deselect done");
    pulse(1);
    pulse(2);
    rdchk(`REG_FLAGS_IDX, flags_of(1, 1, 0, 0));
    apb(1'b1, `REG_FLAGS_IDX, 32'h0);
    rdchk(`REG_FLAGS_IDX, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(errv, 1'b1);
    chk(rdv, 32'h0);
    $display("TEST flags and unmapped done");
    report_and_stop();
  end
endmodule : rtc_supply_and_osc_monitor_tb_top
